// ---- src/ddrb_buf2.sv ----
// Two-entry read data buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "ddrb_map.svh"
module ddrb_buf2 (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic [`DDRB_BUF_W-1:0] in_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic [`DDRB_BUF_W-1:0]      out_data
);
	import ddrb_pkg::*;

	ddrb_buf_t st;
	ddrb_buf_t next_st;
	logic      push;
	logic      pop;

	// Full and empty come straight from the count, so back-pressure is exact
	always_comb
	begin
		next_st   = st;
		in_ready  = (st.cnt != `DDRB_BUF_DEPTH);
		out_valid = (st.cnt != 2'h0);
		out_data  = st.ent[st.rd_ptr];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		if (push)
		begin
			next_st.ent[st.wr_ptr] = in_data;
			next_st.wr_ptr         = ~st.wr_ptr;
		end
		if (pop)
			next_st.rd_ptr = ~st.rd_ptr;
		case ({push, pop})
			2'b10:   next_st.cnt = st.cnt + 2'h1;
			2'b01:   next_st.cnt = st.cnt - 2'h1;
			default: next_st.cnt = st.cnt;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

endmodule : ddrb_buf2
`default_nettype wire

// ---- src/ddrb_map.svh ----
// Named constants for the two-word-burst DDR SRAM interface block
`ifndef DDRB_MAP_SVH
`define DDRB_MAP_SVH

`define DDRB_DATA_W     36
`define DDRB_LANES      4
`define DDRB_NIBBLES    2
`define DDRB_LANE_W     9
`define DDRB_NIB_W      4
`define DDRB_ADDR_W     5
`define DDRB_DEPTH      32
`define DDRB_BUF_W      37
`define DDRB_BUF_DEPTH  2'h2
`define DDRB_BUF_SECOND 36
`define DDRB_LANES_X8   3'h2
`define DDRB_LANES_X9   3'h1
`define DDRB_LANES_X18  3'h2
`define DDRB_LANES_X36  3'h4
`define DDRB_OE_RESET   1'b0
`define DDRB_DATA_RESET 36'h0_0000_0000

`endif

// ---- src/ddrb_pkg.sv ----
// Types shared by the burst SRAM interface block
`default_nettype none
`include "ddrb_map.svh"
package ddrb_pkg;

	// Width variant of the memory seen by the host
	typedef enum logic [1:0] {
		DDRB_X8  = 2'h0,
		DDRB_X9  = 2'h1,
		DDRB_X18 = 2'h2,
		DDRB_X36 = 2'h3
	} ddrb_variant_t;

	// Write burst sequencer, one-hot
	typedef enum logic [2:0] {
		DDRB_WR_IDLE  = 3'h1,
		DDRB_WR_WORD1 = 3'h2,
		DDRB_WR_WORD2 = 3'h4
	} ddrb_wr_state_t;

	typedef struct packed {
		ddrb_wr_state_t             wr_st;
		logic                       wr_queued;
		logic [`DDRB_ADDR_W-1:0]    wr_addr;
		logic [`DDRB_ADDR_W-1:0]    wr2_addr;
		logic                       rd_p1;
		logic                       rd_p2;
		logic [`DDRB_ADDR_W-1:0]    rd_addr;
		logic [`DDRB_ADDR_W-1:0]    rd2_addr;
		logic                       single_mode;
		logic                       strap_done;
		logic [`DDRB_DATA_W-1:0]    data_out;
		logic                       data_oe;
	} ddrb_state_t;

	typedef struct packed {
		logic [1:0][`DDRB_BUF_W-1:0] ent;
		logic [1:0]                  cnt;
		logic                        rd_ptr;
		logic                        wr_ptr;
	} ddrb_buf_t;

endpackage : ddrb_pkg
`default_nettype wire

// ---- src/ddrb_sram.sv ----
// Command, burst and lane-write logic of a two-word-burst DDR SRAM
`timescale 1ns/1ps
`default_nettype none
`include "ddrb_map.svh"
// Behaviour
// - Write: load low, direction low; data t+1
// - Read: words at neg C t+1, C t+2
// - Data timing counted from accepting K cycle
// - Stopped clocks hold data pins unchanged
// - Power-up deselected, outputs high impedance
// - Wide: second address inverts first address LSB
// - Wide: first word uses latched address
// - Narrow: ignore LSB, append 0 then 1
// - Writes on K edges; reads on C/single K
// - x18: two lane selects gate 9-bit halves
// - x8: two nibble selects gate each nibble
// - x9: one select gates whole word
// - Lane selects sampled separately per word
// - NOP: finish read, tristate after positive C
module ddrb_sram #(
	parameter ddrb_pkg::ddrb_variant_t variant = ddrb_pkg::DDRB_X18
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    k_rise,
	input  wire logic                    kn_rise,
	input  wire logic                    c_rise,
	input  wire logic                    cn_rise,
	input  wire logic                    single_clock_strap,
	input  wire logic                    address_load_n,
	input  wire logic                    direction_select,
	input  wire logic [`DDRB_ADDR_W-1:0] address,
	input  wire logic [`DDRB_LANES-1:0]  byte_lane_enable_n,
	input  wire logic [`DDRB_NIBBLES-1:0] nibble_lane_enable_n,
	input  wire logic [`DDRB_DATA_W-1:0] data_in,
	output logic [`DDRB_DATA_W-1:0]      data_out,
	output logic                         data_oe
);
	import ddrb_pkg::*;

	logic [1:0]              rst_pipe;
	logic                    rst_sync_n;
	ddrb_state_t             st;
	ddrb_state_t             next_st;
	logic [`DDRB_DATA_W-1:0] mem [0:`DDRB_DEPTH-1];
	logic                    mem_we;
	logic [`DDRB_ADDR_W-1:0] mem_waddr;
	logic [`DDRB_DATA_W-1:0] mem_wmask;
	logic                    buf_in_valid;
	logic                    buf_in_ready;
	logic [`DDRB_BUF_W-1:0]  buf_in_data;
	logic                    buf_out_valid;
	logic                    buf_out_ready;
	logic [`DDRB_BUF_W-1:0]  buf_out_data;
	logic                    pos_out;
	logic                    neg_out;
	logic                    cmd_write;
	logic                    cmd_read;

	// Burst address of a word; narrow parts carry the burst bit internally
	function automatic logic [`DDRB_ADDR_W-1:0] burst_addr(
		input logic [`DDRB_ADDR_W-1:0] a,
		input logic                    second
	);
		if (variant == DDRB_X8 || variant == DDRB_X9)
			burst_addr = {a[`DDRB_ADDR_W-1:1], second};
		else
			burst_addr = {a[`DDRB_ADDR_W-1:1], a[0] ^ second};
	endfunction : burst_addr

	// Bit enables from the lane selects, per width variant
	function automatic logic [`DDRB_DATA_W-1:0] lane_mask(
		input logic [`DDRB_LANES-1:0]   bl_n,
		input logic [`DDRB_NIBBLES-1:0] nl_n
	);
		logic [2:0] lanes;
		integer     i;
		lanes     = `DDRB_LANES_X36;
		lane_mask = '0;
		case (variant)
			DDRB_X8:  lanes = `DDRB_LANES_X8;
			DDRB_X9:  lanes = `DDRB_LANES_X9;
			DDRB_X18: lanes = `DDRB_LANES_X18;
			default:  lanes = `DDRB_LANES_X36;
		endcase
		for (i = 0; i < `DDRB_DATA_W; i = i + 1)
		begin
			if (variant == DDRB_X8)
			begin
				if (i / `DDRB_NIB_W < lanes)
					lane_mask[i] = !nl_n[i / `DDRB_NIB_W];
			end
			else if (i / `DDRB_LANE_W < lanes)
				lane_mask[i] = !bl_n[i / `DDRB_LANE_W];
		end
	endfunction : lane_mask

	// Reset released through two flops; asynchronous assert
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	assign cmd_write = k_rise && !address_load_n && !direction_select;
	assign cmd_read  = k_rise && !address_load_n && direction_select;
	// Output edges follow C pair, or the K pair in single clock mode
	assign pos_out   = st.single_mode ? k_rise : c_rise;
	assign neg_out   = st.single_mode ? kn_rise : cn_rise;
	// First word leaves on a negative edge, second on a positive one
	assign buf_out_ready = buf_out_data[`DDRB_BUF_SECOND] ? pos_out : neg_out;

	// Next-state logic; only the strap capture moves without a clock pulse, so pins hold
	always_comb
	begin
		next_st      = st;
		mem_we       = 1'b0;
		mem_waddr    = st.wr_addr;
		mem_wmask    = '0;
		buf_in_valid = 1'b0;
		buf_in_data  = '0;
		if (!st.strap_done)
		begin
			next_st.single_mode = single_clock_strap;
			next_st.strap_done  = 1'b1;
		end
		// Write burst: word 1 on K(t+1), word 2 on K#(t+1), lanes per word
		case (st.wr_st)
			DDRB_WR_IDLE:
				if (cmd_write)
				begin
					next_st.wr_addr = address;
					next_st.wr_st   = DDRB_WR_WORD1;
				end
			DDRB_WR_WORD1:
				if (k_rise)
				begin
					mem_we            = 1'b1;
					mem_waddr         = burst_addr(st.wr_addr, 1'b0);
					mem_wmask         = lane_mask(byte_lane_enable_n, nibble_lane_enable_n);
					next_st.wr2_addr  = burst_addr(st.wr_addr, 1'b1);
					next_st.wr_queued = cmd_write;
					if (cmd_write)
						next_st.wr_addr = address;
					next_st.wr_st = DDRB_WR_WORD2;
				end
			DDRB_WR_WORD2:
				if (kn_rise)
				begin
					mem_we        = 1'b1;
					mem_waddr     = st.wr2_addr;
					mem_wmask     = lane_mask(byte_lane_enable_n, nibble_lane_enable_n);
					next_st.wr_st = st.wr_queued ? DDRB_WR_WORD1 : DDRB_WR_IDLE;
				end
			default:
				next_st.wr_st = DDRB_WR_IDLE;
		endcase
		// Read burst: word 1 staged on K(t+1), word 2 on K#(t+1)
		if (kn_rise && st.rd_p2)
		begin
			buf_in_valid = 1'b1;
			buf_in_data  = {1'b1, mem[st.rd2_addr]};
			if (buf_in_ready)
				next_st.rd_p2 = 1'b0;
		end
		if (k_rise && st.rd_p1)
		begin
			buf_in_valid = 1'b1;
			buf_in_data  = {1'b0, mem[burst_addr(st.rd_addr, 1'b0)]};
			if (buf_in_ready)
			begin
				next_st.rd_p1    = 1'b0;
				next_st.rd_p2    = 1'b1;
				next_st.rd2_addr = burst_addr(st.rd_addr, 1'b1);
			end
		end
		if (cmd_read)
		begin
			next_st.rd_p1   = 1'b1;
			next_st.rd_addr = address;
		end
		// Drive popped words; a positive edge with nothing due releases pins
		if (buf_out_valid && buf_out_ready)
		begin
			next_st.data_out = buf_out_data[`DDRB_DATA_W-1:0];
			next_st.data_oe  = 1'b1;
		end
		else if (pos_out)
			next_st.data_oe = 1'b0;
	end

	// State register; power-up leaves the outputs released
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			st          <= '0;
			st.wr_st    <= DDRB_WR_IDLE;
			st.data_oe  <= `DDRB_OE_RESET;
			st.data_out <= `DDRB_DATA_RESET;
		end
		else
			st <= next_st;
	end

	// Array update keeps unselected lanes unaltered
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mem_waddr] <= (mem[mem_waddr] & ~mem_wmask) | (data_in & mem_wmask);
	end

	ddrb_buf2 u_rd_buf (
		.clk       (clk),
		.rst_n     (rst_sync_n),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in_data),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	assign data_out = st.data_out;
	assign data_oe  = st.data_oe;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_n);

	sequence s_read_cmd;
		cmd_read && st.wr_st == DDRB_WR_IDLE;
	endsequence
	sequence s_first_staged;
		k_rise ##1 (st.rd_p2 && !st.rd_p1);
	endsequence

	property p_read_arms;
		s_read_cmd |=> st.rd_p1 && st.rd_addr == $past(address);
	endproperty
	a_read_arms: assert property (p_read_arms) else $error("read not armed");

	property p_write_arms;
		cmd_write && st.wr_st == DDRB_WR_IDLE |=> st.wr_st == DDRB_WR_WORD1;
	endproperty
	a_write_arms: assert property (p_write_arms) else $error("write not armed");

	property p_wide_second;
		k_rise && st.wr_st == DDRB_WR_WORD1 && variant != DDRB_X8 && variant != DDRB_X9
			|=> st.wr2_addr[0] == !$past(st.wr_addr[0]);
	endproperty
	a_wide_second: assert property (p_wide_second) else $error("bad second address");

	property p_narrow_first;
		mem_we && st.wr_st == DDRB_WR_WORD1 && (variant == DDRB_X8 || variant == DDRB_X9)
			|-> mem_waddr[0] == 1'b0;
	endproperty
	a_narrow_first: assert property (p_narrow_first) else $error("narrow first not 0");

	property p_hold_stopped;
		!k_rise && !kn_rise && !c_rise && !cn_rise && st.strap_done
			|=> $stable(data_out) && $stable(data_oe);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped) else $error("pins moved");

	property p_reset_released;
		$rose(rst_sync_n) |-> !data_oe && data_out == `DDRB_DATA_RESET;
	endproperty
	a_reset_released: assert property (p_reset_released) else $error("pins driven");

	property p_nop_release;
		pos_out && !(buf_out_valid && buf_out_ready) |=> !data_oe;
	endproperty
	a_nop_release: assert property (p_nop_release) else $error("no tristate");

	property p_first_word_out;
		neg_out && buf_out_valid && !buf_out_data[`DDRB_BUF_SECOND]
			|=> data_oe && data_out == $past(buf_out_data[`DDRB_DATA_W-1:0]);
	endproperty
	a_first_word_out: assert property (p_first_word_out) else $error("word 1 missing");

	property p_upper_lane_kept;
		mem_we && variant == DDRB_X18 && byte_lane_enable_n[1] |-> mem_wmask[17:9] == 9'h000;
	endproperty
	a_upper_lane_kept: assert property (p_upper_lane_kept) else $error("lane 1 written");

	property p_stage_second;
		s_first_staged |-> ##[1:8] !st.rd_p2 || !buf_in_ready;
	endproperty
	a_stage_second: assert property (p_stage_second) else $error("word 2 stuck");

endmodule : ddrb_sram
`default_nettype wire

// ---- tb/ddrb_host.sv ----
// Host controller model: edge pulses, commands and burst write data
`timescale 1ns/1ps
`default_nettype none
`include "ddrb_map.svh"
module ddrb_host (
	input  wire logic                     clk,
	input  wire logic                     single,
	output logic                          k_rise,
	output logic                          kn_rise,
	output logic                          c_rise,
	output logic                          cn_rise,
	output logic                          address_load_n,
	output logic                          direction_select,
	output logic [`DDRB_ADDR_W-1:0]       address,
	output logic [`DDRB_LANES-1:0]        byte_lane_enable_n,
	output logic [`DDRB_NIBBLES-1:0]      nibble_lane_enable_n,
	output logic [`DDRB_DATA_W-1:0]       data_in
);
	int                ph;
	event              ph_done;
	logic              pw;
	logic [1:0][35:0]  pd;
	logic [1:0][3:0]   pb;
	logic [1:0][1:0]   pn;

	// Idle with clocks parked and no write pending
	initial
	begin
		{k_rise, kn_rise, c_rise, cn_rise} = 4'h0;
		{address_load_n, direction_select, address} = 7'h40;
		{byte_lane_enable_n, nibble_lane_enable_n} = 6'h3f;
		data_in = 36'h0;
		pw = 1'b0;
	end

	// One clk cycle with at most one edge pulse (no C pulse in single mode); the bench judges outputs 1 ns after the edge
	task automatic phase(input int p);
		k_rise  = p == 0;
		c_rise  = p == 1 && !single;
		kn_rise = p == 2;
		cn_rise = p == 3 && !single;
		if (p[0] == 1'b0)
		begin
			data_in              = pw ? pd[p/2] : ~data_in;   // Idle bus wanders
			byte_lane_enable_n   = pw ? pb[p/2] : 4'hf;
			nibble_lane_enable_n = pw ? pn[p/2] : 2'h3;
		end
		@(posedge clk);
		#1;
		ph = p;
		-> ph_done;
		#1;
	endtask : phase

	// One K cycle: a new command with the previous write's data behind it
	task automatic issue(input logic ld_n, rd, input logic [4:0] a,
		input logic [1:0][35:0] d, input logic [1:0][3:0] b, input logic [1:0][1:0] n);
		address_load_n   = ld_n;
		direction_select = rd;
		address          = a;
		for (int p = 0; p < 4; p++)
			phase(p);
		pw = !ld_n && !rd;   // Both words always follow, no burst is cut short
		pd = d;
		pb = b;
		pn = n;
	endtask : issue

	// Stopped clocks: no pulses at all while the command pins wander
	task automatic stall(input int n);
		{k_rise, kn_rise, c_rise, cn_rise} = 4'h0;
		repeat (n)
		begin
			address_load_n   = ~address_load_n;
			direction_select = ~direction_select;
			@(posedge clk);
			#2;
		end
	endtask : stall
endmodule : ddrb_host
`default_nettype wire

// ---- tb/ddrb_sram_tb.sv ----
// Self-checking bench for the burst SRAM block, all four width variants
`timescale 1ns/1ps
`default_nettype none
`include "ddrb_map.svh"
module ddrb_sram_tb;
	import ddrb_pkg::*;
	typedef struct packed {
		logic       ld_n;
		logic       rd;
		logic [4:0] a;
		logic [7:0] v;
		logic [7:0] b;
		logic [3:0] n;
	} ddrb_row_t;
	localparam ddrb_row_t nop = '{1'b1, 1'b0, 5'h00, 8'h00, 8'hff, 4'hf};
	localparam ddrb_row_t rows [10] = '{
		'{1'b0, 1'b0, 5'h03, 8'h3c, 8'h00, 4'h0}, '{1'b0, 1'b0, 5'h04, 8'hc5, 8'h1e, 4'h6},
		'{1'b0, 1'b0, 5'h07, 8'h99, 8'hff, 4'hf}, '{1'b0, 1'b1, 5'h03, 8'h00, 8'hff, 4'hf},
		'{1'b0, 1'b1, 5'h04, 8'h00, 8'hff, 4'hf}, '{1'b0, 1'b1, 5'h07, 8'h00, 8'hff, 4'hf}, nop,
		'{1'b0, 1'b0, 5'h0a, 8'h6e, 8'ha5, 4'h9}, '{1'b0, 1'b1, 5'h0b, 8'h00, 8'hff, 4'hf},
		'{1'b0, 1'b1, 5'h0a, 8'h00, 8'hff, 4'hf}};
	logic              clk, rstn, single, av, bv, wv, last_rd;
	wire               k_rise, kn_rise, c_rise, cn_rise, address_load_n, direction_select;
	wire  [4:0]        address;
	wire  [3:0]        bl_n, oe;
	wire  [1:0]        nl_n;
	wire  [35:0]       din;
	wire  [3:0][35:0]  q, qm;
	logic [3:0][35:0]  aw1, aw2, bw2, hq;
	logic [35:0]       mem [4][32];
	ddrb_row_t         w;
	int                error_cnt = 0;
	int                comparisons = 0;

	// Bits each variant writes for the given active-low selects
	function automatic logic [35:0] lmask(input int g, input logic [3:0] b, input logic [1:0] n);
		case (g)
			0: return {28'h0, {4{~n[1]}}, {4{~n[0]}}};
			1: return {27'h0, {9{~b[0]}}};
			2: return {18'h0, {9{~b[1]}}, {9{~b[0]}}};
			default: return {{9{~b[3]}}, {9{~b[2]}}, {9{~b[1]}}, {9{~b[0]}}};
		endcase
	endfunction : lmask

	// Word address of burst word s
	function automatic logic [4:0] baddr(input int g, input logic [4:0] a, input logic s);
		return (g < 2) ? {a[4:1], s} : a ^ {4'h0, s};
	endfunction : baddr

	// Lanes of the two words get distinct values
	function automatic logic [35:0] dw(input logic [7:0] v, input int s);
		return s ? {4{~v, 1'b1}} : {4{v, 1'b0}};
	endfunction : dw

	ddrb_host h (.clk(clk), .single(single), .k_rise(k_rise), .kn_rise(kn_rise),
		.c_rise(c_rise), .cn_rise(cn_rise), .address_load_n(address_load_n),
		.direction_select(direction_select), .address(address), .byte_lane_enable_n(bl_n),
		.nibble_lane_enable_n(nl_n), .data_in(din));

	// One device per width variant, all fed the same pins
	for (genvar g = 0; g < 4; g++)
	begin : vg
		ddrb_sram #(.variant(ddrb_variant_t'(g))) dut (.clk(clk), .rstn(rstn), .k_rise(k_rise),
			.kn_rise(kn_rise), .c_rise(c_rise), .cn_rise(cn_rise), .single_clock_strap(single),
			.address_load_n(address_load_n), .direction_select(direction_select),
			.address(address), .byte_lane_enable_n(bl_n), .nibble_lane_enable_n(nl_n),
			.data_in(din), .data_out(q[g]), .data_oe(oe[g]));
		assign qm[g] = q[g] & lmask(g, 4'h0, 2'h0);   // Upper bits of narrow parts are unused
	end

	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Word1 after the negative output edge; word2 or release after the positive one
	always @(h.ph_done)
		for (int g = 0; g < 4; g++)
		begin
			if (h.ph == (single ? 2 : 3) && av)
			begin
				chk(36'(oe[g]), 36'h1);
				chk(qm[g], aw1[g]);
			end
			if (h.ph == (single ? 0 : 1))
				chk(36'(oe[g]), 36'(bv));
			if (h.ph == (single ? 0 : 1) && bv)
				chk(qm[g], bw2[g]);
		end

	// One K cycle, then the memory image and expectation pipeline move on
	task automatic step(input ddrb_row_t r);
		logic [35:0] m;
		h.issue(r.ld_n, r.rd, r.a, {dw(r.v, 1), dw(r.v, 0)}, r.b, r.n);
		bv  = av;
		bw2 = aw2;
		av  = !r.ld_n && r.rd;
		for (int g = 0; g < 4; g++)
		begin
			for (int s = 0; s < 2; s++)
			begin
				m = lmask(g, w.b[4*s+:4], w.n[2*s+:2]);
				if (wv)
					mem[g][baddr(g, w.a, 1'(s))] = (mem[g][baddr(g, w.a, 1'(s))] & ~m) | (dw(w.v, s) & m);
			end
			aw1[g] = mem[g][baddr(g, r.a, 1'b0)] & lmask(g, 4'h0, 2'h0);
			aw2[g] = mem[g][baddr(g, r.a, 1'b1)] & lmask(g, 4'h0, 2'h0);
		end
		wv = !r.ld_n && !r.rd;
		w  = r;
	endtask : step

	task automatic op(input ddrb_row_t r);
		if (!r.ld_n && !r.rd && last_rd)
			step(nop);   // Bus turnaround gap
		step(r);
		last_rd = !r.ld_n && r.rd;
	endtask : op

	task automatic do_reset(input logic strap);
		rstn   = 1'b0;
		single = strap;
		repeat (16) @(posedge clk);
		#2;
		rstn = 1'b1;
		repeat (4) @(posedge clk);
		#2;
		for (int g = 0; g < 4; g++)
		begin
			chk(36'(oe[g]), 36'h0);
			chk(q[g], 36'h0);
		end
	endtask : do_reset

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Hang guard, ten times the expected run
	initial
	begin
		#200_000;
		error_cnt++;
		test_done();
	end

	// Fill all words, run the table, then clock stop and single clock mode
	initial
	begin
		{av, bv, wv, last_rd} = 4'h0;
		do_reset(1'b0);
		for (int i = 0; i < 32; i += 2)
			op('{1'b0, 1'b0, 5'(i), 8'(i), 8'h00, 4'h0});
		foreach (rows[i])
			op(rows[i]);
		op('{1'b0, 1'b1, 5'h10, 8'h00, 8'hff, 4'hf});
		hq = aw1;
		op(nop);
		h.stall(6);
		for (int g = 0; g < 4; g++)
		begin
			chk(qm[g], hq[g]);
			chk(36'(oe[g]), 36'h1);
		end
		repeat (2) op(nop);
		// Park the edge pulses so no stale output edge stands through the reset
		h.stall(0);
		do_reset(1'b1);
		op('{1'b0, 1'b0, 5'h15, 8'h5a, 8'h00, 4'h0});
		op('{1'b0, 1'b1, 5'h15, 8'h00, 8'hff, 4'hf});
		repeat (3) op(nop);
		test_done();
	end
endmodule : ddrb_sram_tb
`default_nettype wire
